/* File: src/pmt_program_memory.sv */
/*
  Program store of 8192 x 16 words with program counter, eight-level return
  stack, six prioritised interrupt vectors and the two-cycle table-read path.
  Registers sit on an APB slave with no wait states. The core sequencer drives
  step and branch commands; timer and converter events arrive as one-cycle
  pulses on this clock, and the external interrupt pin is asynchronous.
*/
// The APB slave port and the address map were left to the implementer.
// Functional notes
// R1 - Store is 8192 words of 16 bits, one 13-bit address for fetch and tables.
// R2 - Any reset loads the program counter with address 000H.
// R3 - Enabled external interrupt falling low, stack not full, branches to 004H.
// R4 - Enabled timer 0 overflow, stack not full, branches to 008H.
// R5 - Enabled timer 1 overflow, stack not full, branches to 00CH.
// R6 - Enabled timer 2 overflow, stack not full, branches to 010H.
// R7 - Enabled timer 3 overflow, stack not full, branches to 014H.
// R8 - Enabled converter completion, stack not full, branches to 018H.
// R9 - Software-writable low and high table pointers form the table address.
// R10 - Current-page table read uses high pointer bits 12:8 and low pointer 7:0.
// R11 - Last-page table read forces bits 12:8 high, reading page 1F00H.
// R12 - Table read writes the fetched low byte to the named data register.
// R13 - Table read loads the fetched high byte; unimplemented bits read zero.
// R14 - Table high byte is read-only and changes only on a table read.
// R15 - Each table read takes two cycles, store used for the table in the second.
// R16 - Software should avoid table reads in both main code and service routines.
// R17 - With the stack full, requests stay pending until a return frees a level.
// R18 - Calls and interrupts push the program counter; returns pop it.
// R19 - Simultaneous enabled requests are served lowest vector first.
// R20 - Taking a vector blocks vectoring until re-enable or interrupt return.
`timescale 1ns/1ns

module pmt_program_memory
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmt_pkg::PMT_PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_int_n,
  input wire logic [3:0] tmr_ovf,
  input wire logic adc_done,
  input wire logic step,
  input wire logic jump_req,
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic return_from_interrupt_req,
  input wire logic [pmt_pkg::PMT_AW-1:0] branch_addr,
  output logic [pmt_pkg::PMT_AW-1:0] pc,
  output logic [pmt_pkg::PMT_WW-1:0] fetch_word,
  output logic [pmt_pkg::PMT_LW-1:0] stack_level,
  output logic int_taken,
  input wire logic tbl_rd_req,
  input wire logic tbl_rd_last,
  input wire logic [7:0] tbl_rd_dest,
  output logic tbl_busy,
  output logic tbl_wr_valid,
  output logic [7:0] tbl_wr_dest,
  output logic [7:0] tbl_wr_data
);
  import pmt_pkg::*;

  function automatic logic [PMT_NSRC-1:0] first_req(input logic [PMT_NSRC-1:0] req);
    logic [PMT_NSRC-1:0] sel;
    sel = '0;
    for (int i = PMT_NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        sel = '0;
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction

  function automatic logic [PMT_AW-1:0] vec_of(input logic [PMT_NSRC-1:0] sel);
    logic [PMT_AW-1:0] v;
    v = PMT_VEC_RESET;
    case (sel)
      6'h01: v = PMT_VEC_EXT;
      6'h02: v = PMT_VEC_TMR0;
      6'h04: v = PMT_VEC_TMR1;
      6'h08: v = PMT_VEC_TMR2;
      6'h10: v = PMT_VEC_TMR3;
      6'h20: v = PMT_VEC_ADC;
      default: v = PMT_VEC_RESET;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage and shared signals.

  logic [PMT_WW-1:0] rom_q [0:PMT_DEPTH-1]; // [R1]
  logic [7:0] tbl_low_q, tbl_low_d;
  logic [4:0] tbl_high_q, tbl_high_d;
  logic [PMT_AW-1:0] prog_addr_q, prog_addr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [6:0] int_ctrl_q, int_ctrl_d;
  logic [PMT_NSRC-1:0] pend_q, pend_d, req, sel;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic [PMT_AW-1:0] pc_q, pc_d;
  logic [PMT_AW-1:0] stack_q [0:PMT_STACK_DEPTH-1];
  logic [PMT_AW-1:0] stack_d [0:PMT_STACK_DEPTH-1];
  logic [PMT_LW-1:0] level_q, level_d;
  logic [PMT_WW-1:0] fetch_q, fetch_d;
  logic int_taken_q, stack_full, take_int;
  pmt_tbl_state_t tstate_q, tstate_d;
  logic [PMT_AW-1:0] tbl_addr_q, tbl_addr_d;
  logic [7:0] dest_q, dest_d, wr_data_q, wr_data_d, wr_dest_q, wr_dest_d, high_byte_q, high_byte_d;
  logic wr_valid_q, wr_valid_d;
  logic apb_wr, apb_rd_setup, mapped, prog_we, tbl_start;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave. Zero wait states; read data is captured in the setup cycle so
  // that it comes from a flip-flop when pready is sampled.

  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd_setup = psel & ~penable & ~pwrite;
  assign mapped = (paddr == PMT_OFS_TBL_LOW) | (paddr == PMT_OFS_TBL_HIGH) | (paddr == PMT_OFS_HIGH_BYTE)
    | (paddr == PMT_OFS_INT_CTRL) | (paddr == PMT_OFS_INT_PEND) | (paddr == PMT_OFS_STATUS)
    | (paddr == PMT_OFS_PROG_ADDR) | (paddr == PMT_OFS_PROG_DATA);
  assign pslverr = psel & penable & ~mapped;
  assign prog_we = apb_wr & (paddr == PMT_OFS_PROG_DATA);

  always_comb
  begin
    tbl_low_d = tbl_low_q;
    tbl_high_d = tbl_high_q;
    prog_addr_d = prog_addr_q;
    prdata_d = prdata_q;
    if (apb_wr)
    begin
      case (paddr)
        PMT_OFS_TBL_LOW: tbl_low_d = pwdata[7:0]; // [R9]
        PMT_OFS_TBL_HIGH: tbl_high_d = pwdata[4:0]; // [R9]
        PMT_OFS_PROG_ADDR: prog_addr_d = pwdata[PMT_AW-1:0];
        PMT_OFS_PROG_DATA: prog_addr_d = prog_addr_q + PMT_PC_ONE;
        default: prog_addr_d = prog_addr_q;
      endcase
    end
    if (apb_rd_setup)
    begin
      case (paddr)
        PMT_OFS_TBL_LOW: prdata_d = {24'h000000, tbl_low_q};
        PMT_OFS_TBL_HIGH: prdata_d = {27'h0000000, tbl_high_q};
        PMT_OFS_HIGH_BYTE: prdata_d = {24'h000000, high_byte_q}; // [R13]
        PMT_OFS_INT_CTRL: prdata_d = {25'h0000000, int_ctrl_q};
        PMT_OFS_INT_PEND: prdata_d = {26'h0000000, pend_q};
        PMT_OFS_STATUS: prdata_d = {15'h0000, level_q, pc_q};
        PMT_OFS_PROG_ADDR: prdata_d = {19'h00000, prog_addr_q};
        PMT_OFS_PROG_DATA: prdata_d = {16'h0000, rom_q[prog_addr_q]};
        default: prdata_d = PMT_WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tbl_low_q <= PMT_TBL_LOW_RST;
      tbl_high_q <= PMT_TBL_HIGH_RST;
      prog_addr_q <= PMT_VEC_RESET;
      prdata_q <= PMT_WORD_ZERO;
    end
    else
    begin
      tbl_low_q <= tbl_low_d;
      tbl_high_q <= tbl_high_d;
      prog_addr_q <= prog_addr_d;
      prdata_q <= prdata_d;
    end
  end

  // The store has no reset; software loads it before releasing the core.
  always_ff @(posedge clk)
  begin
    if (prog_we)
    begin
      rom_q[prog_addr_q] <= pwdata[PMT_WW-1:0];
    end
  end

  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests. Pending bits are sticky; a new event in the cycle its
  // bit is served sets it again, so no edge is lost.

  assign stack_full = (level_q == PMT_LEVEL_FULL);
  assign req = pend_q & int_ctrl_q[PMT_NSRC:1];
  assign sel = first_req(req); // [R19]
  assign take_int = step & int_ctrl_q[PMT_GIE_BIT] & (|req) & ~stack_full & ~tbl_busy; // [R17]

  always_comb
  begin
    pend_d = pend_q & ~(take_int ? sel : PMT_PEND_RST);
    pend_d[PMT_SRC_EXT] = pend_d[PMT_SRC_EXT] | (ext_s3_q & ~ext_s2_q); // [R3]
    pend_d[4:1] = pend_d[4:1] | tmr_ovf; // [R4] [R5] [R6] [R7]
    pend_d[PMT_SRC_ADC] = pend_d[PMT_SRC_ADC] | adc_done; // [R8]
    int_ctrl_d = int_ctrl_q;
    if (apb_wr && paddr == PMT_OFS_INT_CTRL)
    begin
      int_ctrl_d = pwdata[6:0];
    end
    if (return_from_interrupt_req)
    begin
      int_ctrl_d[PMT_GIE_BIT] = 1'b1; // [R20]
    end
    if (take_int)
    begin
      int_ctrl_d[PMT_GIE_BIT] = 1'b0; // [R20]
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pend_q <= PMT_PEND_RST;
      int_ctrl_q <= PMT_INT_CTRL_RST;
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_s3_q <= 1'b1;
    end
    else
    begin
      pend_q <= pend_d;
      int_ctrl_q <= int_ctrl_d;
      ext_s1_q <= ext_int_n;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and return stack. A return below an empty stack is
  // ignored; a call on a full stack overwrites the top level and loses the
  // oldest return address never, only the newest.

  always_comb
  begin
    pc_d = pc_q;
    level_d = level_q;
    stack_d = stack_q;
    fetch_d = fetch_q;
    if (take_int)
    begin
      stack_d[level_q[2:0]] = pc_q; // [R18]
      level_d = level_q + PMT_LEVEL_ONE;
      pc_d = vec_of(sel); // [R3] [R4] [R5] [R6] [R7] [R8]
    end
    else if ((ret_req || return_from_interrupt_req) && level_q != PMT_LEVEL_EMPTY)
    begin
      level_d = level_q - PMT_LEVEL_ONE;
      pc_d = stack_q[level_d[2:0]]; // [R18]
    end
    else if (call_req)
    begin
      stack_d[stack_full ? 3'(PMT_STACK_DEPTH - 1) : level_q[2:0]] = pc_q; // [R18]
      level_d = stack_full ? level_q : level_q + PMT_LEVEL_ONE;
      pc_d = branch_addr;
    end
    else if (jump_req)
    begin
      pc_d = branch_addr;
    end
    else if (step)
    begin
      pc_d = pc_q + PMT_PC_ONE;
    end
    // The store serves the table in its access cycle, so fetch holds there.
    if (!tbl_busy)
    begin
      fetch_d = rom_q[pc_d]; // [R1] [R15]
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pc_q <= PMT_VEC_RESET; // [R2]
      level_q <= PMT_LEVEL_EMPTY;
      fetch_q <= '0;
      int_taken_q <= 1'b0;
      for (int i = 0; i < PMT_STACK_DEPTH; i++)
      begin
        stack_q[i] <= PMT_VEC_RESET;
      end
    end
    else
    begin
      pc_q <= pc_d;
      level_q <= level_d;
      fetch_q <= fetch_d;
      int_taken_q <= take_int;
      stack_q <= stack_d;
    end
  end

  assign pc = pc_q;
  assign stack_level = level_q;
  assign fetch_word = fetch_q;
  assign int_taken = int_taken_q;

  ////////////////////////////////////////////////////////////////////////////
  // Table read: the request cycle forms the address, the access cycle reads
  // the store. Software sharing the high byte with a service routine must
  // mask interrupts itself; nothing here saves it.

  assign tbl_busy = (tstate_q == PMT_TBL_ACCESS);
  assign tbl_start = tbl_rd_req & ~tbl_busy;

  always_comb
  begin
    tstate_d = tstate_q;
    tbl_addr_d = tbl_addr_q;
    dest_d = dest_q;
    wr_valid_d = 1'b0;
    wr_data_d = wr_data_q;
    wr_dest_d = wr_dest_q;
    high_byte_d = high_byte_q;
    case (tstate_q)
      PMT_TBL_IDLE:
      begin
        if (tbl_rd_req)
        begin
          tbl_addr_d = {tbl_rd_last ? PMT_LAST_PAGE : tbl_high_q, tbl_low_q}; // [R10] [R11]
          dest_d = tbl_rd_dest;
          tstate_d = PMT_TBL_ACCESS;
        end
      end
      PMT_TBL_ACCESS:
      begin
        wr_valid_d = 1'b1; // [R15]
        wr_data_d = rom_q[tbl_addr_q][7:0]; // [R12]
        wr_dest_d = dest_q; // [R12]
        high_byte_d = rom_q[tbl_addr_q][15:8]; // [R13] [R14]
        tstate_d = PMT_TBL_IDLE;
      end
      default: tstate_d = PMT_TBL_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tstate_q <= PMT_TBL_IDLE;
      tbl_addr_q <= PMT_VEC_RESET;
      dest_q <= 8'h00;
      wr_valid_q <= 1'b0;
      wr_data_q <= 8'h00;
      wr_dest_q <= 8'h00;
      high_byte_q <= PMT_HIGH_BYTE_RST;
    end
    else
    begin
      tstate_q <= tstate_d;
      tbl_addr_q <= tbl_addr_d;
      dest_q <= dest_d;
      wr_valid_q <= wr_valid_d;
      wr_data_q <= wr_data_d;
      wr_dest_q <= wr_dest_d;
      high_byte_q <= high_byte_d;
    end
  end

  assign tbl_wr_valid = wr_valid_q;
  assign tbl_wr_data = wr_data_q;
  assign tbl_wr_dest = wr_dest_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_reset_pc;
    disable iff (1'b0) reset |=> pc_q == PMT_VEC_RESET;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset"); // [R2]

  property p_vector;
    take_int |=> pc_q == vec_of($past(sel)) && !int_ctrl_q[PMT_GIE_BIT];
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector or enable left set"); // [R3] [R20]

  property p_adc_vec;
    take_int && req == 6'h20 |=> pc_q == PMT_VEC_ADC;
  endproperty
  a_adc_vec: assert property (p_adc_vec) else $error("converter vector wrong"); // [R8]

  property p_prio;
    take_int && req[PMT_SRC_EXT] |=> pc_q == PMT_VEC_EXT;
  endproperty
  a_prio: assert property (p_prio) else $error("external request not served first"); // [R19]

  property p_full_hold;
    stack_full && (|req) |=> (pend_q & $past(req)) == $past(req);
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("vector taken on full stack"); // [R17]

  property p_push;
    take_int |=> level_q == $past(level_q) + PMT_LEVEL_ONE && stack_q[$past(level_q[2:0])] == $past(pc_q);
  endproperty
  a_push: assert property (p_push) else $error("return address not pushed"); // [R18]

  property p_two_cycle;
    tbl_start |=> tbl_busy ##1 (wr_valid_q && !tbl_busy);
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("table read not two cycles"); // [R15]

  property p_last_page;
    tbl_start && tbl_rd_last |=> tbl_addr_q == {PMT_LAST_PAGE, $past(tbl_low_q)};
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong"); // [R11]

  property p_cur_page;
    tbl_start && !tbl_rd_last |=> tbl_addr_q == {$past(tbl_high_q), $past(tbl_low_q)};
  endproperty
  a_cur_page: assert property (p_cur_page) else $error("current page address wrong"); // [R10]

  property p_hb_only_table;
    $changed(high_byte_q) |-> $past(tstate_q) == PMT_TBL_ACCESS && wr_valid_q;
  endproperty
  a_hb_only_table: assert property (p_hb_only_table) else $error("high byte changed outside table read"); // [R14]

  c_int_taken: cover property (take_int);
  c_full_pending: cover property (stack_full && (|req) ##[1:20] take_int);
  c_last_read: cover property (tbl_start && tbl_rd_last ##2 wr_valid_q);
  c_call_ret: cover property (call_req ##[1:20] ret_req);

endmodule

/* File: src/pmt_pkg.sv */
/*
  Shared constants for the program memory, vector and table-read block:
  sizes, vector addresses, APB register offsets, field positions and reset values.
  Assumes a 32-bit APB with byte addresses and one aligned word per register.
*/
package pmt_pkg;

  localparam int PMT_AW = 13;
  localparam int PMT_DEPTH = 8192;
  localparam int PMT_WW = 16;
  localparam int PMT_STACK_DEPTH = 8;
  localparam int PMT_LW = 4;
  localparam int PMT_NSRC = 6;
  localparam int PMT_PAW = 12;

  localparam logic [PMT_AW-1:0] PMT_VEC_RESET = 13'h0000;
  localparam logic [PMT_AW-1:0] PMT_VEC_EXT = 13'h0004;
  localparam logic [PMT_AW-1:0] PMT_VEC_TMR0 = 13'h0008;
  localparam logic [PMT_AW-1:0] PMT_VEC_TMR1 = 13'h000C;
  localparam logic [PMT_AW-1:0] PMT_VEC_TMR2 = 13'h0010;
  localparam logic [PMT_AW-1:0] PMT_VEC_TMR3 = 13'h0014;
  localparam logic [PMT_AW-1:0] PMT_VEC_ADC = 13'h0018;
  localparam logic [PMT_AW-1:0] PMT_PC_ONE = 13'h0001;
  localparam logic [4:0] PMT_LAST_PAGE = 5'h1F;
  localparam logic [PMT_LW-1:0] PMT_LEVEL_FULL = 4'h8;
  localparam logic [PMT_LW-1:0] PMT_LEVEL_ONE = 4'h1;
  localparam logic [PMT_LW-1:0] PMT_LEVEL_EMPTY = 4'h0;

  // Pending and enable bit positions, lowest index has highest priority.
  localparam int PMT_SRC_EXT = 0;
  localparam int PMT_SRC_ADC = 5;
  localparam int PMT_GIE_BIT = 0;

  localparam logic [PMT_PAW-1:0] PMT_OFS_TBL_LOW = 12'h000;
  localparam logic [PMT_PAW-1:0] PMT_OFS_TBL_HIGH = 12'h004;
  localparam logic [PMT_PAW-1:0] PMT_OFS_HIGH_BYTE = 12'h008;
  localparam logic [PMT_PAW-1:0] PMT_OFS_INT_CTRL = 12'h00C;
  localparam logic [PMT_PAW-1:0] PMT_OFS_INT_PEND = 12'h010;
  localparam logic [PMT_PAW-1:0] PMT_OFS_STATUS = 12'h014;
  localparam logic [PMT_PAW-1:0] PMT_OFS_PROG_ADDR = 12'h018;
  localparam logic [PMT_PAW-1:0] PMT_OFS_PROG_DATA = 12'h01C;

  localparam logic [7:0] PMT_TBL_LOW_RST = 8'h00;
  localparam logic [4:0] PMT_TBL_HIGH_RST = 5'h00;
  localparam logic [7:0] PMT_HIGH_BYTE_RST = 8'h00;
  localparam logic [6:0] PMT_INT_CTRL_RST = 7'h00;
  localparam logic [5:0] PMT_PEND_RST = 6'h00;
  localparam logic [31:0] PMT_WORD_ZERO = 32'h0000_0000;

  typedef enum logic
  {
    PMT_TBL_IDLE = 1'b0,
    PMT_TBL_ACCESS = 1'b1
  } pmt_tbl_state_t;

endpackage

/* File: tb/pmt_core_model.sv */
/*
  Behavioural model of the core sequencer: program stepping, branch commands
  and table-read requests. Assumes its tasks are called one at a time.
*/
`timescale 1ns/1ns

module pmt_core_model
(
  input wire logic clk,
  output logic step,
  output logic jump_req,
  output logic call_req,
  output logic ret_req,
  output logic return_from_interrupt_req,
  output logic [pmt_pkg::PMT_AW-1:0] branch_addr,
  output logic tbl_rd_req,
  output logic tbl_rd_last,
  output logic [7:0] tbl_rd_dest
);
  import pmt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // The core keeps stepping, so every cycle is an instruction boundary.
  initial
  begin
    step = 1'b1;
    jump_req = 1'b0;
    call_req = 1'b0;
    ret_req = 1'b0;
    return_from_interrupt_req = 1'b0;
    branch_addr = 13'h0000;
    tbl_rd_req = 1'b0;
    tbl_rd_last = 1'b0;
    tbl_rd_dest = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Kind 0 jumps, 1 calls, 2 returns, 3 returns from interrupt.
  // Qualifiers are inverted once released, so stale values cannot pass.
  task automatic command(input int kind, input logic [PMT_AW-1:0] addr);
    @(posedge clk);
    branch_addr <= addr;
    jump_req <= (kind == 0);
    call_req <= (kind == 1);
    ret_req <= (kind == 2);
    return_from_interrupt_req <= (kind == 3);
    @(posedge clk);
    branch_addr <= ~addr;
    jump_req <= 1'b0;
    call_req <= 1'b0;
    ret_req <= 1'b0;
    return_from_interrupt_req <= 1'b0;
  endtask

  // Only issued while vectoring is masked, so no service routine can disturb the high byte.
  task automatic table_read(input logic last, input logic [7:0] dest);
    @(posedge clk);
    tbl_rd_req <= 1'b1;
    tbl_rd_last <= last;
    tbl_rd_dest <= dest;
    @(posedge clk);
    tbl_rd_req <= 1'b0;
    tbl_rd_last <= ~last;
    tbl_rd_dest <= ~dest;
  endtask
endmodule

/* File: tb/program_rom_vectors_table_read_test.sv */
/*
  Self-checking testbench for the program store, vectors and table reads.
  Assumes an APB master with zero-wait slave and the core model beside it.
*/
`timescale 1ns/1ns

module program_rom_vectors_table_read_test;
  import pmt_pkg::*;

  logic clk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_int_n;
  logic [3:0] tmr_ovf;
  logic adc_done;
  logic step;
  logic jump_req;
  logic call_req;
  logic ret_req;
  logic return_from_interrupt_req;
  logic [12:0] branch_addr;
  logic [12:0] pc;
  logic [15:0] fetch_word;
  logic [3:0] stack_level;
  logic int_taken;
  logic tbl_rd_req;
  logic tbl_rd_last;
  logic [7:0] tbl_rd_dest;
  logic tbl_busy;
  logic tbl_wr_valid;
  logic [7:0] tbl_wr_dest;
  logic [7:0] tbl_wr_data;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  logic hit;
  logic [12:0] vec [6] = '{PMT_VEC_EXT, PMT_VEC_TMR0, PMT_VEC_TMR1, PMT_VEC_TMR2, PMT_VEC_TMR3, PMT_VEC_ADC};

  pmt_program_memory DUT
  (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_int_n(ext_int_n),
    .tmr_ovf(tmr_ovf), .adc_done(adc_done), .step(step), .jump_req(jump_req), .call_req(call_req),
    .ret_req(ret_req), .return_from_interrupt_req(return_from_interrupt_req), .branch_addr(branch_addr), .pc(pc), .fetch_word(fetch_word),
    .stack_level(stack_level), .int_taken(int_taken), .tbl_rd_req(tbl_rd_req), .tbl_rd_last(tbl_rd_last),
    .tbl_rd_dest(tbl_rd_dest), .tbl_busy(tbl_busy), .tbl_wr_valid(tbl_wr_valid),
    .tbl_wr_dest(tbl_wr_dest), .tbl_wr_data(tbl_wr_data)
  );

  pmt_core_model core
  (
    .clk(clk), .step(step), .jump_req(jump_req), .call_req(call_req), .ret_req(ret_req),
    .return_from_interrupt_req(return_from_interrupt_req), .branch_addr(branch_addr), .tbl_rd_req(tbl_rd_req),
    .tbl_rd_last(tbl_rd_last), .tbl_rd_dest(tbl_rd_dest)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole run needs a few hundred cycles; a hang stops well past that.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic raise(input logic [5:0] src);
    @(posedge clk);
    tmr_ovf <= src[4:1];
    adc_done <= src[5];
    @(posedge clk);
    tmr_ovf <= 4'h0;
    adc_done <= 1'b0;
  endtask

  task automatic wait_int(input int limit);
    hit = 1'b0;
    for (int i = 0; i < limit && !hit; i++)
    begin
      @(posedge clk);
      #1;
      hit = (int_taken === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    #1;
    check("pc", pc, PMT_VEC_RESET);
    check("stack_level", stack_level, PMT_LEVEL_EMPTY);
    for (int a = 0; a < 5; a++)
    begin
      apb(1'b0, 12'(a * 4), 32'h0);
      check("reg_reset", rd, 32'h0);
    end
  endtask

  task automatic t_regs();
    apb(1'b1, PMT_OFS_TBL_LOW, 32'hFFFF_FFFF);
    apb(1'b0, PMT_OFS_TBL_LOW, 32'h0);
    check("table_address_low", rd, 32'hFF);
    apb(1'b1, PMT_OFS_TBL_HIGH, 32'hFFFF_FFFF);
    apb(1'b0, PMT_OFS_TBL_HIGH, 32'h0);
    check("table_address_high", rd, 32'h1F);
    apb(1'b1, PMT_OFS_HIGH_BYTE, 32'hAB);
    apb(1'b0, PMT_OFS_HIGH_BYTE, 32'h0);
    check("table_high_byte", rd, 32'h0);
    apb(1'b0, 12'h0F0, 32'h0);
    check("unmapped_err", err, 32'h1);
    check("pready", pready, 32'h1);
  endtask

  task automatic tbl(input logic last, input logic [7:0] dest, input logic [15:0] exp);
    core.table_read(last, dest);
    #1;
    check("tbl_busy", tbl_busy, 32'h1);
    @(posedge clk);
    #1;
    check("tbl_wr_valid", tbl_wr_valid, 32'h1);
    check("tbl_wr_dest", tbl_wr_dest, dest);
    check("tbl_wr_data", tbl_wr_data, exp[7:0]);
    apb(1'b0, PMT_OFS_HIGH_BYTE, 32'h0);
    check("table_high_byte", rd, exp[15:8]);
  endtask

  // Vectoring stays masked here, as table reads must not race a service routine.
  task automatic t_table();
    apb(1'b1, PMT_OFS_PROG_ADDR, 32'h1F05);
    apb(1'b1, PMT_OFS_PROG_DATA, 32'h0F0F);
    apb(1'b1, PMT_OFS_PROG_DATA, 32'hA51A);
    apb(1'b1, PMT_OFS_PROG_ADDR, 32'h0306);
    apb(1'b1, PMT_OFS_PROG_DATA, 32'h5C3F);
    apb(1'b1, PMT_OFS_TBL_LOW, 32'h06);
    apb(1'b1, PMT_OFS_TBL_HIGH, 32'h03);
    tbl(1'b0, 8'h21, 16'h5C3F);
    tbl(1'b1, 8'h22, 16'hA51A);
    apb(1'b1, PMT_OFS_TBL_LOW, 32'h05);
    tbl(1'b1, 8'h23, 16'h0F0F);
    core.command(0, 13'h1F06);
    #1;
    check("pc", pc, 32'h1F06);
    check("fetch_word", fetch_word, 32'hA51A);
  endtask

  task automatic t_vectors();
    for (int i = 1; i < 6; i++)
    begin
      apb(1'b1, PMT_OFS_INT_CTRL, 32'h1 | (32'h1 << (i + 1)));
      raise(6'h01 << i);
      wait_int(20);
      check("int_taken", hit, 32'h1);
      check("pc", pc, vec[i]);
      check("stack_level", stack_level, 32'h1);
      core.command(3, 13'h0000);
      #1;
      check("stack_level", stack_level, 32'h0);
    end
  endtask

  task automatic t_priority();
    apb(1'b1, PMT_OFS_INT_CTRL, 32'h01);
    raise(6'h02);
    wait_int(8);
    check("int_taken", hit, 32'h0);
    apb(1'b1, PMT_OFS_INT_CTRL, 32'h7E);
    raise(6'h24);
    apb(1'b1, PMT_OFS_INT_CTRL, 32'h7F);
    wait_int(20);
    check("pc", pc, vec[1]);
    wait_int(8);
    check("int_taken", hit, 32'h0);
    apb(1'b0, PMT_OFS_INT_PEND, 32'h0);
    check("pending", rd, 32'h24);
    core.command(3, 13'h0000);
    wait_int(20);
    check("pc", pc, vec[2]);
    core.command(3, 13'h0000);
    wait_int(20);
    check("pc", pc, vec[5]);
    core.command(3, 13'h0000);
  endtask

  task automatic t_ext();
    apb(1'b1, PMT_OFS_INT_CTRL, 32'h03);
    @(posedge clk);
    ext_int_n <= 1'b0;
    wait_int(20);
    check("pc", pc, vec[0]);
    @(posedge clk);
    ext_int_n <= 1'b1;
    core.command(3, 13'h0000);
  endtask

  task automatic t_stack();
    apb(1'b1, PMT_OFS_INT_CTRL, 32'h0);
    repeat (8) core.command(1, 13'h0040);
    #1;
    check("stack_level", stack_level, 32'h8);
    apb(1'b1, PMT_OFS_INT_CTRL, 32'h05);
    raise(6'h02);
    wait_int(10);
    check("int_taken", hit, 32'h0);
    apb(1'b0, PMT_OFS_INT_PEND, 32'h0);
    check("pending", rd, 32'h02);
    core.command(2, 13'h0000);
    wait_int(20);
    check("pc", pc, vec[1]);
    check("stack_level", stack_level, 32'h8);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_int_n = 1'b1;
    tmr_ovf = 4'h0;
    adc_done = 1'b0;
    do_reset();
    t_reset();
    t_regs();
    t_table();
    t_vectors();
    t_priority();
    t_ext();
    t_stack();
    do_reset();
    t_reset();
    results();
  end
endmodule
